// ---- core/qir_pkg.sv ----
package qir_pkg;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MAX = 8'h04;
   localparam logic [7:0] OFF_CNT = 8'h08;
   localparam logic [7:0] OFF_INIT = 8'h0C;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_IFLAG = 8'h14;
   localparam logic [7:0] OFF_IMASK = 8'h18;
   localparam int CTRL_W = 4;
   localparam int CTRL_EN = 0;
   localparam int CTRL_CRS_LO = 1;
   localparam int CTRL_CRS_HI = 2;
   localparam int CTRL_IEI = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [1:0] CRS_INDEX = 2'h0;
   localparam int STAT_FIRST_INDEX_SEEN_FLAG = 0;
   localparam int STAT_FIRST_INDEX_DIRECTION_FLAG = 1;
   localparam int STAT_DIR = 2;
   localparam int STAT_EDGE_LO = 3;
   localparam int STAT_EDGE_HI = 4;
   localparam int INT_W = 4;
   localparam int INT_IDX = 0;
   localparam int INT_DIRCHG = 1;
   localparam int INT_WRAP = 2;
   localparam int INT_PHERR = 3;
   localparam logic [3:0] IMASK_RST = 4'h0;
   localparam logic [31:0] MAX_RST = 32'hFFFFFFFF;
   localparam logic [31:0] INIT_RST = 32'h00000000;
   localparam int SYNC_STAGES = 2;
endpackage : qir_pkg

// ---- core/qir_qdec.sv ----
`timescale 1ns/1ps
module qir_qdec (
   input wire logic clk_i,          // clock
   input wire logic rst_i,          // sync reset, high
   input wire logic a_i,            // synchronised phase a
   input wire logic b_i,            // synchronised phase b
   output logic edge_o,             // one legal quadrature step, pulse
   output logic fwd_o,              // direction of that step
   output logic dirchg_o,           // direction reversed, pulse
   output logic pherr_o,            // both phases moved, pulse
   output logic [1:0] state_o,      // current phase state {a,b}
   output logic dir_o               // last direction, 1 forward
);
   logic [1:0] prev_q;
   logic dir_q;
   logic [1:0] cur;
   logic moved;
   logic both;
   logic fwd;
   assign cur = {a_i, b_i};
   assign moved = cur != prev_q;
   assign both = &(cur ^ prev_q);
   // forward sequence 00 01 11 10
   assign fwd = (prev_q == 2'h0 && cur == 2'h1) ||
                (prev_q == 2'h1 && cur == 2'h3) ||
                (prev_q == 2'h3 && cur == 2'h2) ||
                (prev_q == 2'h2 && cur == 2'h0);
   assign edge_o = moved & ~both;
   assign fwd_o = fwd;
   assign pherr_o = both;
   assign dirchg_o = edge_o & (fwd != dir_q);
   assign state_o = cur;
   assign dir_o = dir_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 2'h0;
         dir_q <= 1'b1;
      end else begin
         prev_q <= cur;
         if (edge_o) begin
            dir_q <= fwd;
         end
      end
   end
endmodule : qir_qdec

// ---- core/qir_sync.sv ----
`timescale 1ns/1ps
module qir_sync #(
   parameter int W = 3
) (
   input wire logic clk_i,          // clock
   input wire logic rst_i,          // sync reset, high
   input wire logic [W-1:0] d_i,    // asynchronous pins
   output logic [W-1:0] q_o         // synchronised levels
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   genvar g;
   // first stage feeds only the second stage
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= d_i[g];
               s2_q[g] <= s1_q[g];
            end
         end
      end
   endgenerate
   assign q_o = s2_q;
endmodule : qir_sync

// ---- core/qir_top.sv ----
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module qir_top #(
   parameter int CNT_W = 32
) (
   input wire logic clk_i,          // 100 MHz clock
   input wire logic rst_i,          // sync reset, high
   input wire logic psel_i,         // apb select
   input wire logic penable_i,      // apb enable
   input wire logic pwrite_i,       // apb write
   input wire logic [7:0] paddr_i,  // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic [31:0] prdata_o,    // apb read data
   output logic pready_o,           // apb ready
   output logic pslverr_o,          // apb error, unmapped address
   input wire logic qa_i,           // encoder phase a pin
   input wire logic qb_i,           // encoder phase b pin
   input wire logic qi_i,           // encoder index pin
   output logic [CNT_W-1:0] position_count_o, // current count
   output logic irq_o               // level interrupt
);
   // synchronised pins
   logic [2:0] pins_s;
   logic a_s;
   logic b_s;
   logic idx_s;

   qir_sync #(
      .W(3)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({qi_i, qb_i, qa_i}),
      .q_o(pins_s)
   );

   assign a_s = pins_s[0];
   assign b_s = pins_s[1];
   assign idx_s = pins_s[2];

   logic q_edge;
   logic q_fwd;
   logic q_dirchg;
   logic q_pherr;
   logic [1:0] q_state;
   logic q_dir;

   qir_qdec u_qdec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .a_i(a_s),
      .b_i(b_s),
      .edge_o(q_edge),
      .fwd_o(q_fwd),
      .dirchg_o(q_dirchg),
      .pherr_o(q_pherr),
      .state_o(q_state),
      .dir_o(q_dir)
   );

   // registers
   logic [qir_pkg::CTRL_W-1:0] decoder_control_q;
   logic [CNT_W-1:0] position_max_q;
   logic [CNT_W-1:0] position_init_q;
   logic [CNT_W-1:0] position_count_q;
   logic [CNT_W-1:0] position_count_d;
   logic first_index_seen_flag_q;
   logic first_index_direction_flag_q;
   logic [1:0] index_edge_q;
   logic [qir_pkg::INT_W-1:0] int_flag_q;
   logic [qir_pkg::INT_W-1:0] int_flag_d;
   logic [qir_pkg::INT_W-1:0] int_mask_q;
   logic [31:0] prdata_q;

   // apb decode
   logic setup;
   logic wr;
   logic sel_ctrl;
   logic sel_max;
   logic sel_cnt;
   logic sel_init;
   logic sel_stat;
   logic sel_iflag;
   logic sel_imask;
   logic mapped;

   assign setup = psel_i & ~penable_i;
   assign wr = psel_i & penable_i & pwrite_i;
   assign sel_ctrl = paddr_i == qir_pkg::OFF_CTRL;
   assign sel_max = paddr_i == qir_pkg::OFF_MAX;
   assign sel_cnt = paddr_i == qir_pkg::OFF_CNT;
   assign sel_init = paddr_i == qir_pkg::OFF_INIT;
   assign sel_stat = paddr_i == qir_pkg::OFF_STAT;
   assign sel_iflag = paddr_i == qir_pkg::OFF_IFLAG;
   assign sel_imask = paddr_i == qir_pkg::OFF_IMASK;
   assign mapped = sel_ctrl | sel_max | sel_cnt | sel_init | sel_stat |
                   sel_iflag | sel_imask;

   // zero wait states: data is caught in the setup cycle
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped;
   assign prdata_o = prdata_q;

   // control fields
   logic en;
   logic [1:0] counter_reset_select;
   logic index_event_init;
   logic index_reset_mode;

   assign en = decoder_control_q[qir_pkg::CTRL_EN];
   assign counter_reset_select =
      decoder_control_q[qir_pkg::CTRL_CRS_HI:qir_pkg::CTRL_CRS_LO];
   assign index_event_init = decoder_control_q[qir_pkg::CTRL_IEI];
   assign index_reset_mode = counter_reset_select == qir_pkg::CRS_INDEX;

   // status word
   logic [31:0] decoder_status;
   always_comb begin
      decoder_status = 32'h00000000;
      decoder_status[qir_pkg::STAT_FIRST_INDEX_SEEN_FLAG] = first_index_seen_flag_q;
      decoder_status[qir_pkg::STAT_FIRST_INDEX_DIRECTION_FLAG] = first_index_direction_flag_q;
      decoder_status[qir_pkg::STAT_DIR] = q_dir;
      decoder_status[qir_pkg::STAT_EDGE_HI:qir_pkg::STAT_EDGE_LO] =
         index_edge_q;
   end

   // read mux
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h00000000;
      if (sel_ctrl) begin
         rdata[qir_pkg::CTRL_W-1:0] = decoder_control_q;
      end
      if (sel_max) begin
         rdata[CNT_W-1:0] = position_max_q;
      end
      if (sel_cnt) begin
         rdata[CNT_W-1:0] = position_count_q;
      end
      if (sel_init) begin
         rdata[CNT_W-1:0] = position_init_q;
      end
      if (sel_stat) begin
         rdata = decoder_status;
      end
      if (sel_iflag) begin
         rdata[qir_pkg::INT_W-1:0] = int_flag_q;
      end
      if (sel_imask) begin
         rdata[qir_pkg::INT_W-1:0] = int_mask_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prdata_q <= 32'h00000000;
      end else if (setup & ~pwrite_i) begin
         prdata_q <= rdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         decoder_control_q <= qir_pkg::CTRL_RST;
         position_max_q <= qir_pkg::MAX_RST[CNT_W-1:0];
         position_init_q <= qir_pkg::INIT_RST[CNT_W-1:0];
         int_mask_q <= qir_pkg::IMASK_RST;
      end else if (wr) begin
         if (sel_ctrl) begin
            decoder_control_q <= pwdata_i[qir_pkg::CTRL_W-1:0];
         end
         if (sel_max) begin
            position_max_q <= pwdata_i[CNT_W-1:0];
         end
         if (sel_init) begin
            position_init_q <= pwdata_i[CNT_W-1:0];
         end
         if (sel_imask) begin
            int_mask_q <= pwdata_i[qir_pkg::INT_W-1:0];
         end
      end
   end

   // index pulse tracking
   logic idx_prev_q;
   logic idx_armed_q;
   logic idx_rise;
   logic idx_hit;
   logic first_hit;
   logic later_hit;
   logic first_index_seen_flag_clr;

   assign idx_rise = en & idx_s & ~idx_prev_q;
   // one reset per index pulse; the pulse ends the arming so a bad
   // earlier pulse can never leak into the next one
   assign first_hit = idx_armed_q & idx_s & q_edge &
                      ~first_index_seen_flag_q;
   assign later_hit = idx_armed_q & idx_s & q_edge &
                      first_index_seen_flag_q &
                      (q_state == index_edge_q);
   assign idx_hit = first_hit | later_hit;
   assign first_index_seen_flag_clr = wr & sel_stat & pwdata_i[qir_pkg::STAT_FIRST_INDEX_SEEN_FLAG];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idx_prev_q <= 1'b0;
         idx_armed_q <= 1'b0;
      end else begin
         idx_prev_q <= idx_s;
         if (idx_rise) begin
            idx_armed_q <= 1'b1;
         end else if (idx_hit | ~idx_s | ~en) begin
            idx_armed_q <= 1'b0;
         end
      end
   end

   // first index capture; a new first index wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_index_seen_flag_q <= 1'b0;
         first_index_direction_flag_q <= 1'b0;
         index_edge_q <= 2'h0;
      end else if (first_hit) begin
         first_index_seen_flag_q <= 1'b1;
         first_index_direction_flag_q <= q_fwd;
         index_edge_q <= q_state;
      end else if (first_index_seen_flag_clr) begin
         first_index_seen_flag_q <= 1'b0;
      end
   end

   // reset lands on the clock after the qualifying edge
   logic rst_pend_q;
   logic rst_fwd_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_pend_q <= 1'b0;
         rst_fwd_q <= 1'b0;
      end else begin
         rst_pend_q <= idx_hit & index_reset_mode;
         rst_fwd_q <= q_fwd;
      end
   end

   // counter
   logic at_max;
   logic at_zero;
   logic wrap;
   logic cnt_wr;

   assign at_max = position_count_q == position_max_q;
   assign at_zero = position_count_q == '0;
   assign cnt_wr = wr & sel_cnt;
   assign wrap = en & q_edge & ~rst_pend_q &
                 (q_fwd ? at_max : at_zero);

   always_comb begin
      position_count_d = position_count_q;
      if (cnt_wr) begin
         position_count_d = pwdata_i[CNT_W-1:0];
      end else if (rst_pend_q) begin
         if (rst_fwd_q) begin
            position_count_d = '0;
         end else begin
            position_count_d = position_max_q;
         end
      end else if (idx_rise & index_event_init) begin
         position_count_d = position_init_q;
      end else if (en & q_edge) begin
         if (q_fwd) begin
            position_count_d = at_max ? '0 : position_count_q + 1'b1;
         end else begin
            position_count_d = at_zero ? position_max_q :
                               position_count_q - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         position_count_q <= '0;
      end else begin
         position_count_q <= position_count_d;
      end
   end

   assign position_count_o = position_count_q;

   // interrupts: sticky, write one to clear, set wins
   logic [qir_pkg::INT_W-1:0] int_set;
   logic [qir_pkg::INT_W-1:0] int_clr;

   always_comb begin
      int_set = '0;
      int_set[qir_pkg::INT_IDX] = idx_rise;
      int_set[qir_pkg::INT_DIRCHG] = en & q_dirchg;
      int_set[qir_pkg::INT_WRAP] = wrap;
      int_set[qir_pkg::INT_PHERR] = en & q_pherr;
   end

   assign int_clr = (wr & sel_iflag) ? pwdata_i[qir_pkg::INT_W-1:0] : '0;
   assign int_flag_d = int_set | (int_flag_q & ~int_clr);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_flag_q <= '0;
      end else begin
         int_flag_q <= int_flag_d;
      end
   end

   assign irq_o = |(int_flag_q & int_mask_q);

endmodule : qir_top

// ---- sim/qir_enc.sv ----
`timescale 1ns/1ps
module qir_enc (
   input wire logic clk_i, // clock
   output logic qa_o, // phase a
   output logic qb_o, // phase b
   output logic qi_o // index
);
   logic [1:0] ph;
   // gray order 00,01,11,10 so only one phase moves per step
   assign qa_o = ph[1];
   assign qb_o = ph[1] ^ ph[0];
   task automatic step(input logic fwd, input int gap);
      ph <= fwd ? ph + 2'h1 : ph - 2'h1;
      repeat (gap) @(posedge clk_i);
   endtask : step
   // quiet pins with the phases at 00, set before reset is released
   task automatic park();
      ph <= 2'h0;
      qi_o <= 1'b0;
   endtask : park
   // hold long enough for the index to pass the synchroniser
   task automatic mark(input logic lvl);
      qi_o <= lvl;
      repeat (4) @(posedge clk_i);
   endtask : mark
endmodule : qir_enc

// ---- sim/qir_top_assertions.sv ----
`timescale 1ns/1ps
module qir_top_assertions #(parameter int CNT_W = 32) (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic psel_i, // apb
   input wire logic penable_i, // apb
   input wire logic pwrite_i, // apb
   input wire logic [7:0] paddr_i, // apb
   input wire logic [31:0] pwdata_i, // apb
   input wire logic [31:0] prdata_o, // apb
   input wire logic pready_o, // apb
   input wire logic pslverr_o, // apb
   input wire logic qa_i, // pin
   input wire logic qb_i, // pin
   input wire logic qi_i, // pin
   input wire logic [CNT_W-1:0] position_count_o, // count
   input wire logic irq_o // interrupt
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [CNT_W-1:0] cnt, max_q, init_q;
   logic [3:0] mask_q;
   logic [1:0] wr_q;
   wire acc = psel_i && penable_i;
   wire wr = acc && pwrite_i;
   wire mapped = paddr_i <= 8'h18 && paddr_i[1:0] == 2'h0;
   // a software load of the count is not a hardware step
   wire quiet = !wr && wr_q == 2'h0;
   assign cnt = position_count_o;
   always_ff @(posedge clk_i) begin
      wr_q <= {wr_q[0], wr};
      if (rst_i) begin
         max_q <= qir_pkg::MAX_RST[CNT_W-1:0];
         init_q <= qir_pkg::INIT_RST[CNT_W-1:0];
         mask_q <= qir_pkg::IMASK_RST;
      end else if (wr) begin
         if (paddr_i == qir_pkg::OFF_MAX) max_q <= pwdata_i[CNT_W-1:0];
         if (paddr_i == qir_pkg::OFF_INIT) init_q <= pwdata_i[CNT_W-1:0];
         if (paddr_i == qir_pkg::OFF_IMASK) mask_q <= pwdata_i[3:0];
      end
   end
   AST_PREADY: assert property (acc |-> pready_o)
      else $error("pready low in access");
   AST_SLVERR: assert property (acc |-> pslverr_o == !mapped)
      else $error("pslverr wrong");
   AST_UNMAP_RD: assert property (acc && !pwrite_i && !mapped |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   AST_RST: assert property ($past(rst_i) |-> cnt == '0 && !irq_o)
      else $error("reset state wrong");
   AST_IRQ_MASK: assert property (mask_q == 4'h0 |-> !irq_o)
      else $error("irq with all masked");
   AST_STEP: assert property ($changed(cnt) && quiet |->
      cnt == $past(cnt) + 1'b1 || cnt == $past(cnt) - 1'b1 || cnt == '0
      || cnt == max_q || cnt == init_q) else $error("count jumped");
   AST_HOLD: assert property (($stable({qa_i, qb_i, qi_i}) && quiet) [*6]
      |-> $stable(cnt)) else $error("count moved without pins");
   AST_FWD_ZERO: assert property ($changed(cnt) && cnt == '0 && quiet
      && $past(cnt) != 1 && $past(cnt) != max_q
      |-> $past(cnt) == $past(cnt, 2) + 1'b1) else $error("zero load");
   AST_REV_MAX: assert property ($changed(cnt) && cnt == max_q && quiet
      && $past(cnt) != 0 && $past(cnt) + 1'b1 != max_q
      |-> $past(cnt) + 1'b1 == $past(cnt, 2)) else $error("max load");
   COV_FWD: cover property ($changed(cnt) && cnt == '0 && quiet);
   COV_REV: cover property ($changed(cnt) && cnt == max_q && quiet);
   COV_IRQ: cover property ($rose(irq_o));
endmodule : qir_top_assertions
bind qir_top qir_top_assertions #(.CNT_W(CNT_W)) qir_top_assertions_i (
   .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .qa_i(qa_i), .qb_i(qb_i), .qi_i(qi_i),
   .position_count_o(position_count_o), .irq_o(irq_o));

// ---- sim/qir_top_tb.sv ----
`timescale 1ns/1ps
module qir_top_tb;
   localparam logic [31:0] MAXV = 32'h00000009;
   logic clk_i;
   logic rst_i;
   logic psel_i;
   logic penable_i;
   logic pwrite_i;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i;
   logic [31:0] prdata_o, position_count_o, cnt_e;
   logic pready_o, pslverr_o, qa_i, qb_i, qi_i, irq_o;
   logic [32:0] exp_q[$];
   logic [31:0] seed = 32'h00000029;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   qir_top qir_top_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .qa_i(qa_i), .qb_i(qb_i), .qi_i(qi_i),
      .position_count_o(position_count_o), .irq_o(irq_o));
   qir_enc qir_enc_i (.clk_i(clk_i), .qa_o(qa_i), .qb_o(qb_i), .qi_o(qi_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic chk(input logic [32:0] s, input logic [32:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e);
      if (!w) exp_q.push_back(e);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 33'h0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      bus(1'b0, a, 32'h0, e);
   endtask : rd
   task automatic setc(input logic [31:0] v);
      wr(qir_pkg::OFF_CNT, v);
      cnt_e = v;
   endtask : setc
   // model steps and follow them in the expected count, wrapping 0..MAXV
   task automatic walk(input logic f, input int n);
      repeat (n) begin
         qir_enc_i.step(f, 2 + int'(rnd() % 4));
         if (f) cnt_e = (cnt_e == MAXV) ? 32'h0 : cnt_e + 32'h1;
         else cnt_e = (cnt_e == 32'h0) ? MAXV : cnt_e - 32'h1;
      end
      repeat (6) @(posedge clk_i);
   endtask : walk
   // every index pulse starts from phase 00 so the stored edge is known
   task automatic align();
      while (qir_enc_i.ph != 2'h0) walk(1'b1, 1);
   endtask : align
   task automatic fwd_index();
      qir_enc_i.mark(1'b1);
      walk(1'b1, 1);
      cnt_e = 32'h0;
      walk(1'b1, 3);
      qir_enc_i.mark(1'b0);
   endtask : fwd_index
   always @(posedge clk_i) begin
      if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
         if (exp_q.size() == 0) chk(33'h0, 33'h1FFFFFFFF);
         else chk({pslverr_o, prdata_o}, exp_q.pop_front());
      end
   end
   // the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
   initial begin
      rst_i <= 1'b1;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      pwrite_i <= 1'b0;
      paddr_i <= 8'h00;
      pwdata_i <= 32'h00000000;
      qir_enc_i.park();
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(qir_pkg::OFF_CTRL, 33'h0);
      rd(qir_pkg::OFF_MAX, {1'b0, qir_pkg::MAX_RST});
      rd(qir_pkg::OFF_CNT, 33'h0);
      rd(qir_pkg::OFF_IMASK, 33'h0);
      rd(8'h1C, 33'h100000000);
      wr(qir_pkg::OFF_MAX, MAXV);
      wr(qir_pkg::OFF_CTRL, 32'h1);
      setc(rnd() % 10);
      walk(1'b1, 3 + int'(rnd() % 8));
      rd(qir_pkg::OFF_CNT, {1'b0, cnt_e});
      walk(1'b0, 13);
      rd(qir_pkg::OFF_CNT, {1'b0, cnt_e});
      chk({1'b0, position_count_o}, {1'b0, cnt_e});
      align();
      walk(1'b1, 4);
      setc(32'h5);
      wr(qir_pkg::OFF_IFLAG, 32'hF);
      wr(qir_pkg::OFF_IMASK, 32'h1);
      fwd_index();
      rd(qir_pkg::OFF_CNT, {1'b0, cnt_e});
      rd(qir_pkg::OFF_STAT, 33'hF);
      rd(qir_pkg::OFF_IFLAG, 33'h1);
      chk({32'h0, irq_o}, 33'h1);
      wr(qir_pkg::OFF_IFLAG, 32'h1);
      chk({32'h0, irq_o}, 33'h0);
      wr(qir_pkg::OFF_IMASK, 32'h0);
      walk(1'b0, 4);
      setc(32'h5);
      qir_enc_i.mark(1'b1);
      walk(1'b0, 3);
      cnt_e = MAXV;
      walk(1'b0, 1);
      qir_enc_i.mark(1'b0);
      rd(qir_pkg::OFF_CNT, {1'b0, cnt_e});
      rd(qir_pkg::OFF_STAT, 33'hB);
      // reversal and the wrap through zero left their flags up
      rd(qir_pkg::OFF_IFLAG, 33'h7);
      chk({32'h0, irq_o}, 33'h0);
      wr(qir_pkg::OFF_IMASK, 32'h1);
      chk({32'h0, irq_o}, 33'h1);
      wr(qir_pkg::OFF_IFLAG, 32'hF);
      chk({32'h0, irq_o}, 33'h0);
      // a reversal while the index is high may upset this pulse only
      qir_enc_i.mark(1'b1);
      walk(1'b1, 2);
      walk(1'b0, 2);
      qir_enc_i.mark(1'b0);
      walk(1'b1, 4);
      setc(32'h5);
      fwd_index();
      rd(qir_pkg::OFF_CNT, {1'b0, cnt_e});
      for (int m = 1; m < 4; m++) begin
         wr(qir_pkg::OFF_CTRL, 32'h1 | 32'(m << 1));
         setc(32'h5);
         qir_enc_i.mark(1'b1);
         walk(1'b1, 4);
         qir_enc_i.mark(1'b0);
         rd(qir_pkg::OFF_CNT, {1'b0, cnt_e});
      end
      // index_event_init in a non-reset mode: the rise loads the init value
      cnt_e = rnd() % 10;
      wr(qir_pkg::OFF_INIT, cnt_e);
      rd(qir_pkg::OFF_INIT, {1'b0, cnt_e});
      wr(qir_pkg::OFF_CTRL, 32'h0000000B);
      qir_enc_i.mark(1'b1);
      walk(1'b1, 4);
      qir_enc_i.mark(1'b0);
      rd(qir_pkg::OFF_CNT, {1'b0, cnt_e});
      chk({1'b0, position_count_o}, {1'b0, cnt_e});
      report_and_stop();
   end
endmodule : qir_top_tb
